//--- scd_regs.svh
// constants for the storage card command decoder: opcodes, field positions,
// diagnostic codes and timing counts; assumes a 250 MHz core clock
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH

`define SCD_OP_CHKPWR_A 8'he5
`define SCD_OP_CHKPWR_B 8'h98
`define SCD_OP_DIAG 8'h90
`define SCD_OP_ERASE 8'hc0
`define SCD_OP_FLUSH 8'he7
`define SCD_OP_FORMAT 8'h50
`define SCD_OP_IDENT 8'hec
`define SCD_OP_IDLE_A 8'he3
`define SCD_OP_IDLE_B 8'h97
`define SCD_OP_IDLEI_A 8'he1
`define SCD_OP_IDLEI_B 8'h95
`define SCD_OP_INITP 8'h91
`define SCD_OP_KEYMGT 8'hb9
`define SCD_OP_NOP 8'h00
`define SCD_OP_RDBUF 8'he4
`define SCD_OP_RDDMA 8'hc8
`define SCD_OP_RDLONG_A 8'h22
`define SCD_OP_RDLONG_B 8'h23
`define SCD_OP_RDMULT 8'hc4
`define SCD_OP_RDSEC_A 8'h20
`define SCD_OP_RDSEC_B 8'h21
`define SCD_OP_RDVER_A 8'h40
`define SCD_OP_RDVER_B 8'h41
`define SCD_OP_RECAL_HI 4'h1
`define SCD_OP_SEEK_HI 4'h7
`define SCD_OP_SENSE 8'h03
`define SCD_OP_SECDIS 8'hf6
`define SCD_OP_SECERP 8'hf3
`define SCD_OP_SECERU 8'hf4
`define SCD_OP_SECFRZ 8'hf5
`define SCD_OP_SECSET 8'hf1
`define SCD_OP_SECUNL 8'hf2
`define SCD_OP_SETFEAT 8'hef
`define SCD_OP_SETMULT 8'hc6
`define SCD_OP_SLEEP_A 8'he6
`define SCD_OP_SLEEP_B 8'h99
`define SCD_OP_STBY_A 8'he2
`define SCD_OP_STBY_B 8'h96
`define SCD_OP_STBYI_A 8'he0
`define SCD_OP_STBYI_B 8'h94
`define SCD_OP_XLATE 8'h87
`define SCD_OP_WRBUF 8'he8
`define SCD_OP_WRDMA 8'hca
`define SCD_OP_WRLONG_A 8'h32
`define SCD_OP_WRLONG_B 8'h33
`define SCD_OP_WRMULT 8'hc5
`define SCD_OP_WRMULTNE 8'hcd
`define SCD_OP_WRSEC_A 8'h30
`define SCD_OP_WRSEC_B 8'h31
`define SCD_OP_WRSECNE 8'h38
`define SCD_OP_WRVER 8'h3c

`define SCD_KEY_FEAT_RDKEY 8'h80
`define SCD_KEY_FEAT_CHGKEY 8'h81

`define SCD_DH_DRV_BIT 4
`define SCD_DH_LBA_BIT 6
`define SCD_DIAG_OK 8'h01
`define SCD_DIAG_SLAVE_NIB 4'h8
`define SCD_SC_ASLEEP 8'h00
`define SCD_SC_IDLE 8'hff

`define SCD_CLK_MHZ 250
`define SCD_T_BUSY_NS 400
`define SCD_T_DRQ2_US 700
`define SCD_T_DRQ3_MS 20
`define SCD_BUSY_CYC ((`SCD_T_BUSY_NS * `SCD_CLK_MHZ) / 1000)
`define SCD_DRQ2_CYC (`SCD_T_DRQ2_US * `SCD_CLK_MHZ)
`define SCD_DRQ3_CYC (`SCD_T_DRQ3_MS * 1000 * `SCD_CLK_MHZ)
`define SCD_PREP_CYC 16

`endif

//--- scd_pkg.sv
// types shared by the command decoder and its erase sequencer
package scd_pkg;

    typedef enum logic [1:0] {
        SCD_CLS_NONE = 2'd0,
        SCD_CLS_ONE = 2'd1,
        SCD_CLS_TWO = 2'd2,
        SCD_CLS_THREE = 2'd3
    } scd_class_type;

    typedef enum logic [4:0] {
        SCD_OPK_INVALID, SCD_OPK_CHKPWR, SCD_OPK_DIAG, SCD_OPK_ERASE,
        SCD_OPK_FLUSH, SCD_OPK_FORMAT, SCD_OPK_IDENT, SCD_OPK_IDLE,
        SCD_OPK_IDLEI, SCD_OPK_INITP, SCD_OPK_KEY_STRUCT, SCD_OPK_KEY_READ,
        SCD_OPK_KEY_CHANGE, SCD_OPK_NOP, SCD_OPK_RDBUF, SCD_OPK_RDDMA,
        SCD_OPK_RDLONG, SCD_OPK_RDMULT, SCD_OPK_RDSEC, SCD_OPK_RDVER,
        SCD_OPK_RECAL, SCD_OPK_SENSE, SCD_OPK_SECURITY, SCD_OPK_SEEK,
        SCD_OPK_SETFEAT, SCD_OPK_SETMULT, SCD_OPK_SLEEP, SCD_OPK_STBY,
        SCD_OPK_STBYI, SCD_OPK_XLATE, SCD_OPK_WRITE, SCD_OPK_WRMULT
    } scd_op_type;

    // task file as written by the host
    typedef struct packed {
        logic [7:0] features;
        logic [7:0] sector_count;
        logic [7:0] sector_number;
        logic [7:0] cyl_low;
        logic [7:0] cyl_high;
        logic [7:0] drive_head;
    } scd_taskfile_type;

    // parameters the decoder passes on, only the marked ones are valid
    typedef struct packed {
        logic fr_valid;
        logic sc_valid;
        logic sn_valid;
        logic cy_valid;
        logic head_valid;
        logic drive;
        logic lba_mode;
        logic [27:0] lba;
        logic [7:0] count;
    } scd_params_type;

endpackage : scd_pkg

//--- scd_erase.sv
// erase sequencer: walks the addressed sectors, holding the erase request
// high from start until the last sector's ack; assumes the media side acks each sector
`timescale 1ns/1ps
module scd_erase
    import scd_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control
    input wire logic i_start,
    input wire logic [27:0] i_lba,
    input wire logic [7:0] i_count,
    // media side
    output logic o_erase_req,
    output logic [27:0] o_erase_lba,
    input wire logic i_erase_ack,
    input wire logic i_erase_fault,
    // result
    output logic o_done,
    output logic o_fault
);

    logic [8:0] left_q;
    logic busy_q;

    // -------------------------------------------------------------
    // sector walk
    // -------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            left_q <= 9'h000;
            busy_q <= 1'b0;
            o_erase_lba <= 28'h0000000;
            o_fault <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                // count of zero means 256 sectors
                left_q <= (i_count == 8'h00) ? 9'h100 : {1'b0, i_count};
                o_erase_lba <= i_lba;
                busy_q <= 1'b1;
                o_fault <= 1'b0;
            end else if (busy_q && i_erase_ack) begin
                o_erase_lba <= o_erase_lba + 28'h0000001;
                o_fault <= o_fault | i_erase_fault;
                left_q <= left_q - 9'h001;
                if (left_q == 9'h001) begin
                    busy_q <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end

    assign o_erase_req = busy_q;

endmodule : scd_erase

//--- scd_decoder.sv
// command decoder and executor of the storage card task file
// assumes the host writes the command only while busy is clear and that
// task-file inputs are synchronous to i_clk
`timescale 1ns/1ps
`include "scd_regs.svh"
module scd_decoder
    import scd_pkg::*;
(
    // clock and reset (hardware or soft reset)
    input wire logic i_clk,
    input wire logic i_rst,
    // command write
    input wire logic i_cmd_wr,
    input wire logic [7:0] i_cmd_code,
    input wire scd_taskfile_type i_taskfile,
    // configuration and card state
    input wire logic i_direct_disk_mode,
    input wire logic i_is_slave,
    input wire logic i_asleep,
    input wire logic [7:0] i_self_test_code,
    // slave diagnostic line, from a pin
    input wire logic i_diag_pass_line,
    // media side of the erase
    output logic o_erase_req,
    output logic [27:0] o_erase_lba,
    input wire logic i_erase_ack,
    input wire logic i_erase_fault,
    // buffer preparation finished, from the buffer manager
    input wire logic i_buf_ready,
    // status and results
    output logic o_busy_flag,
    output logic o_data_request_flag,
    output logic o_write_fault_flag,
    output logic o_error_flag,
    output logic o_abort,
    output logic o_irq_req,
    output logic [7:0] o_error_reg,
    output logic [7:0] o_sector_count_reg,
    output logic o_sc_load,
    output scd_class_type o_class,
    output scd_op_type o_op,
    output scd_params_type o_params,
    output logic o_timeout
);

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_EXEC = 5'b00010,
        ST_WAIT = 5'b00100,
        ST_DRQ = 5'b01000,
        ST_DONE = 5'b10000
    } scd_state_type;

    // -------------------------------------------------------------
    // decode functions
    // -------------------------------------------------------------
    function automatic scd_op_type decode_op(input logic [7:0] c,
                                             input logic [7:0] f);
        scd_op_type op;
        op = SCD_OPK_INVALID;
        unique case (c)
            `SCD_OP_CHKPWR_A, `SCD_OP_CHKPWR_B: op = SCD_OPK_CHKPWR;
            `SCD_OP_DIAG: op = SCD_OPK_DIAG;
            `SCD_OP_ERASE: op = SCD_OPK_ERASE;
            `SCD_OP_FLUSH: op = SCD_OPK_FLUSH;
            `SCD_OP_FORMAT: op = SCD_OPK_FORMAT;
            `SCD_OP_IDENT: op = SCD_OPK_IDENT;
            `SCD_OP_IDLE_A, `SCD_OP_IDLE_B: op = SCD_OPK_IDLE;
            `SCD_OP_IDLEI_A, `SCD_OP_IDLEI_B: op = SCD_OPK_IDLEI;
            `SCD_OP_INITP: op = SCD_OPK_INITP;
            `SCD_OP_KEYMGT: begin
                // features pick the subcommand
                if (f == `SCD_KEY_FEAT_RDKEY) begin
                    op = SCD_OPK_KEY_READ;
                end else if (f == `SCD_KEY_FEAT_CHGKEY) begin
                    op = SCD_OPK_KEY_CHANGE;
                end else if (!f[7]) begin
                    op = SCD_OPK_KEY_STRUCT;
                end
            end
            `SCD_OP_NOP: op = SCD_OPK_NOP;
            `SCD_OP_RDBUF: op = SCD_OPK_RDBUF;
            `SCD_OP_RDDMA: op = SCD_OPK_RDDMA;
            `SCD_OP_RDLONG_A, `SCD_OP_RDLONG_B: op = SCD_OPK_RDLONG;
            `SCD_OP_RDMULT: op = SCD_OPK_RDMULT;
            `SCD_OP_RDSEC_A, `SCD_OP_RDSEC_B: op = SCD_OPK_RDSEC;
            `SCD_OP_RDVER_A, `SCD_OP_RDVER_B: op = SCD_OPK_RDVER;
            `SCD_OP_SENSE: op = SCD_OPK_SENSE;
            `SCD_OP_SECDIS, `SCD_OP_SECERP, `SCD_OP_SECERU,
            `SCD_OP_SECFRZ, `SCD_OP_SECSET, `SCD_OP_SECUNL:
                op = SCD_OPK_SECURITY;
            `SCD_OP_SETFEAT: op = SCD_OPK_SETFEAT;
            `SCD_OP_SETMULT: op = SCD_OPK_SETMULT;
            `SCD_OP_SLEEP_A, `SCD_OP_SLEEP_B: op = SCD_OPK_SLEEP;
            `SCD_OP_STBY_A, `SCD_OP_STBY_B: op = SCD_OPK_STBY;
            `SCD_OP_STBYI_A, `SCD_OP_STBYI_B: op = SCD_OPK_STBYI;
            `SCD_OP_XLATE: op = SCD_OPK_XLATE;
            `SCD_OP_WRBUF, `SCD_OP_WRDMA, `SCD_OP_WRLONG_A, `SCD_OP_WRLONG_B,
            `SCD_OP_WRSEC_A, `SCD_OP_WRSEC_B, `SCD_OP_WRSECNE:
                op = SCD_OPK_WRITE;
            `SCD_OP_WRMULT, `SCD_OP_WRMULTNE, `SCD_OP_WRVER:
                op = SCD_OPK_WRMULT;
            default: begin
                if (c[7:4] == `SCD_OP_RECAL_HI) begin
                    op = SCD_OPK_RECAL;
                end else if (c[7:4] == `SCD_OP_SEEK_HI) begin
                    op = SCD_OPK_SEEK;
                end
            end
        endcase
        return op;
    endfunction : decode_op

    function automatic scd_class_type op_class(input scd_op_type op);
        scd_class_type cl;
        if (op == SCD_OPK_INVALID) begin
            cl = SCD_CLS_NONE;
        end else if (op == SCD_OPK_WRMULT) begin
            cl = SCD_CLS_THREE;
        end else if (op == SCD_OPK_WRITE || op == SCD_OPK_FORMAT ||
                     op == SCD_OPK_KEY_CHANGE) begin
            cl = SCD_CLS_TWO;
        end else begin
            cl = SCD_CLS_ONE;
        end
        return cl;
    endfunction : op_class

    // valid-register mask {fr, sc, sn, cy, head}
    function automatic logic [4:0] op_mask(input scd_op_type op);
        logic [4:0] m;
        m = 5'h00;
        unique case (op)
            SCD_OPK_ERASE, SCD_OPK_RDDMA, SCD_OPK_RDMULT, SCD_OPK_RDSEC,
            SCD_OPK_RDVER, SCD_OPK_XLATE, SCD_OPK_WRITE, SCD_OPK_WRMULT:
                m = 5'b01111;
            SCD_OPK_RDLONG, SCD_OPK_SEEK: m = 5'b00111;
            SCD_OPK_FORMAT: m = 5'b01011;
            SCD_OPK_INITP: m = 5'b01001;
            SCD_OPK_IDLE, SCD_OPK_SETMULT: m = 5'b01000;
            SCD_OPK_SETFEAT: m = 5'b10000;
            SCD_OPK_KEY_STRUCT, SCD_OPK_KEY_READ, SCD_OPK_KEY_CHANGE:
                m = 5'b11110;
            default: m = 5'h00;
        endcase
        return m;
    endfunction : op_mask

    // -------------------------------------------------------------
    // decode of the written code
    // -------------------------------------------------------------
    scd_op_type op_d;
    scd_class_type cls_d;
    logic [4:0] mask_d;
    logic [7:0] dh;
    assign op_d = decode_op(i_cmd_code, i_taskfile.features);
    assign cls_d = op_class(op_d);
    assign mask_d = op_mask(op_d);
    assign dh = i_taskfile.drive_head;

    // diag pin synchroniser
    logic diag_pass_line_meta_q;
    logic diag_pass_line_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            diag_pass_line_meta_q <= 1'b0;
            diag_pass_line_q <= 1'b0;
        end else begin
            diag_pass_line_meta_q <= i_diag_pass_line;
            diag_pass_line_q <= diag_pass_line_meta_q;
        end
    end

    // -------------------------------------------------------------
    // latched command and parameters
    // -------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_op <= SCD_OPK_NOP;
            o_class <= SCD_CLS_NONE;
            o_params <= '0;
        end else if (i_cmd_wr && !o_busy_flag) begin
            o_op <= op_d;
            o_class <= cls_d;
            o_params.fr_valid <= mask_d[4];
            o_params.sc_valid <= mask_d[3];
            o_params.sn_valid <= mask_d[2];
            o_params.cy_valid <= mask_d[1];
            o_params.head_valid <= mask_d[0];
            o_params.drive <= dh[`SCD_DH_DRV_BIT];
            o_params.lba_mode <= dh[`SCD_DH_LBA_BIT];
            o_params.lba <= {dh[3:0], i_taskfile.cyl_high,
                             i_taskfile.cyl_low,
                             i_taskfile.sector_number};
            o_params.count <= i_taskfile.sector_count;
        end
    end

    // -------------------------------------------------------------
    // execution sequence
    // -------------------------------------------------------------
    scd_state_type state_q;
    logic [23:0] tmr_q;
    logic [23:0] limit_q;
    logic erase_start;
    logic erase_done;
    logic erase_fault;
    logic run_here;

    // removable mode runs only on the selected card, direct disk on both
    assign run_here = i_direct_disk_mode ||
                      (dh[`SCD_DH_DRV_BIT] == i_is_slave);
    assign erase_start = (state_q == ST_EXEC) && (o_op == SCD_OPK_ERASE);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            tmr_q <= 24'h000000;
            limit_q <= 24'h000000;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    tmr_q <= 24'h000000;
                    if (i_cmd_wr && run_here) begin
                        state_q <= ST_EXEC;
                        limit_q <= (cls_d == SCD_CLS_THREE) ?
                            24'(`SCD_DRQ3_CYC) : 24'(`SCD_DRQ2_CYC);
                    end
                end
                ST_EXEC: begin
                    if (o_class == SCD_CLS_TWO || o_class == SCD_CLS_THREE) begin
                        state_q <= ST_WAIT;
                    end else if (o_op == SCD_OPK_ERASE) begin
                        state_q <= ST_WAIT;
                    end else begin
                        state_q <= ST_DONE;
                    end
                end
                ST_WAIT: begin
                    tmr_q <= tmr_q + 24'h000001;
                    if (o_op == SCD_OPK_ERASE) begin
                        if (erase_done) begin
                            state_q <= ST_DONE;
                        end
                    end else if (i_buf_ready ||
                                 tmr_q == limit_q - 24'h000001) begin
                        state_q <= ST_DRQ;
                    end
                end
                ST_DRQ: state_q <= ST_IDLE;
                ST_DONE: state_q <= ST_IDLE;
            endcase
        end
    end

    // status flags and result registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_busy_flag <= 1'b0;
            o_data_request_flag <= 1'b0;
            o_write_fault_flag <= 1'b0;
            o_error_flag <= 1'b0;
            o_abort <= 1'b0;
            o_irq_req <= 1'b0;
            o_error_reg <= 8'h00;
            o_sector_count_reg <= 8'h00;
            o_sc_load <= 1'b0;
            o_timeout <= 1'b0;
        end else begin
            o_irq_req <= 1'b0;
            o_sc_load <= 1'b0;
            if (state_q == ST_IDLE && i_cmd_wr && run_here) begin
                o_busy_flag <= 1'b1;
                o_data_request_flag <= 1'b0;
                o_error_flag <= 1'b0;
                o_abort <= 1'b0;
                o_write_fault_flag <= 1'b0;
                o_timeout <= 1'b0;
            end
            if (state_q == ST_WAIT && o_op != SCD_OPK_ERASE &&
                !i_buf_ready && tmr_q == limit_q - 24'h000001) begin
                o_timeout <= 1'b1;
            end
            if (state_q == ST_WAIT && o_op != SCD_OPK_ERASE &&
                (i_buf_ready || tmr_q == limit_q - 24'h000001)) begin
                o_data_request_flag <= 1'b1;
            end
            if (state_q == ST_DRQ) begin
                o_busy_flag <= 1'b0;
            end
            if (state_q == ST_DONE) begin
                o_busy_flag <= 1'b0;
                o_irq_req <= 1'b1;
                unique case (o_op)
                    SCD_OPK_INVALID: begin
                        o_error_flag <= 1'b1;
                        o_abort <= 1'b1;
                    end
                    SCD_OPK_CHKPWR: begin
                        o_sc_load <= 1'b1;
                        o_sector_count_reg <= i_asleep ?
                            `SCD_SC_ASLEEP : `SCD_SC_IDLE;
                    end
                    SCD_OPK_DIAG: begin
                        if (i_direct_disk_mode && !i_is_slave && !diag_pass_line_q) begin
                            o_error_reg <= {`SCD_DIAG_SLAVE_NIB,
                                            i_self_test_code[3:0]};
                        end else begin
                            o_error_reg <= i_self_test_code;
                        end
                        o_error_flag <= (i_self_test_code != `SCD_DIAG_OK);
                    end
                    SCD_OPK_ERASE: begin
                        o_write_fault_flag <= erase_fault;
                        o_error_flag <= erase_fault;
                    end
                    default: o_sc_load <= 1'b0;
                endcase
            end
        end
    end

    // -------------------------------------------------------------
    // erase sequencer
    // -------------------------------------------------------------
    scd_erase u_erase (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_start(erase_start),
        .i_lba(o_params.lba),
        .i_count(o_params.count),
        .o_erase_req(o_erase_req),
        .o_erase_lba(o_erase_lba),
        .i_erase_ack(i_erase_ack),
        .i_erase_fault(i_erase_fault),
        .o_done(erase_done),
        .o_fault(erase_fault)
    );

endmodule : scd_decoder

//--- scd_monitor.sv
// checker for scd_decoder: decode classes, busy and completion timing
// assumes it is bound to scd_decoder and sees only that module's ports
`timescale 1ns/1ps
module scd_monitor
    import scd_pkg::*;
(
    // clock, reset, command write and card configuration
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cmd_wr,
    input wire logic [7:0] i_cmd_code,
    input wire scd_taskfile_type i_taskfile,
    input wire logic i_direct_disk_mode,
    input wire logic i_is_slave,
    input wire logic i_asleep,
    // status
    input wire logic o_busy_flag,
    input wire logic o_data_request_flag,
    input wire logic o_error_flag,
    input wire logic o_abort,
    input wire logic o_irq_req,
    input wire logic o_sc_load,
    input wire logic [7:0] o_sector_count_reg,
    input wire logic o_erase_req,
    input wire scd_class_type o_class
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic take;
    assign take = i_cmd_wr && !o_busy_flag && (i_direct_disk_mode ||
        i_taskfile.drive_head[4] == i_is_slave);
    sequence s_run;
        o_busy_flag [*2] ##1 (!o_busy_flag && o_irq_req);
    endsequence
    property p_busy; take |=> o_busy_flag; endproperty
    property p_done;
        take && i_cmd_code inside {8'h00, 8'he5, 8'h98} |=> s_run;
    endproperty
    property p_cls3;
        take && i_cmd_code inside {8'hc5, 8'hcd, 8'h3c}
            |=> o_class == SCD_CLS_THREE;
    endproperty
    property p_cls2;
        take && i_cmd_code inside {8'h30, 8'h31, 8'h38, 8'hca, 8'h32,
            8'h33, 8'he8, 8'h50} |=> o_class == SCD_CLS_TWO;
    endproperty
    property p_idle;
        take && i_cmd_code inside {8'he5, 8'h98} && !i_asleep
            |-> ##3 o_sc_load && o_sector_count_reg == 8'hff;
    endproperty
    property p_drq; $rose(o_data_request_flag) |=> !o_busy_flag; endproperty
    property p_bad;
        take && i_cmd_code == 8'hff |-> ##3 o_error_flag && o_abort;
    endproperty
    property p_erase; o_erase_req |-> !o_data_request_flag; endproperty
    a_busy: assert property (p_busy) else $error("busy late");
    a_done: assert property (p_done) else $error("no finish");
    a_cls3: assert property (p_cls3) else $error("not three");
    a_cls2: assert property (p_cls2) else $error("not two");
    a_idle: assert property (p_idle) else $error("idle count");
    a_drq: assert property (p_drq) else $error("busy held");
    a_bad: assert property (p_bad) else $error("no abort");
    a_erase: assert property (p_erase) else $error("erase data");
endmodule : scd_monitor

bind scd_decoder scd_monitor scd_monitor_i (.*);

//--- scd_media_model.sv
// media side model: acks each erase request after a chosen delay
// assumes the request is held until its ack; delay of at least one
`timescale 1ns/1ps
module scd_media_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // erase handshake
    input wire logic i_erase_req,
    input wire logic [3:0] i_delay,
    input wire logic i_fault_en,
    output logic o_erase_ack,
    output logic o_erase_fault
);
    logic [3:0] wait_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_q <= 4'h0;
            o_erase_ack <= 1'b0;
        end else begin
            o_erase_ack <= 1'b0;
            wait_q <= 4'h0;
            if (i_erase_req && !o_erase_ack && wait_q < i_delay) begin
                wait_q <= wait_q + 4'h1;
            end else if (i_erase_req && !o_erase_ack) begin
                o_erase_ack <= 1'b1;
            end
        end
    end
    assign o_erase_fault = o_erase_ack && i_fault_en;
endmodule : scd_media_model

//--- tb_scd_decoder.sv
// testbench for scd_decoder: classes, power, diagnostic, erase, abort
// assumes the media model answers erase requests
`timescale 1ns/1ps
module tb_scd_decoder
    import scd_pkg::*;
;
    logic i_clk = 1'b0, i_rst = 1'b1, i_cmd_wr = 1'b0, i_asleep = 1'b0;
    logic i_direct_disk_mode = 1'b0, i_is_slave = 1'b0, i_buf_ready = 1'b1;
    logic i_diag_pass_line = 1'b1, fault_en = 1'b0;
    logic [7:0] i_cmd_code = 8'h00, i_self_test_code = 8'h01;
    logic [3:0] dly = 4'h1;
    scd_taskfile_type i_taskfile = '0;
    logic o_busy_flag, o_data_request_flag, o_write_fault_flag, o_error_flag;
    logic o_abort, o_irq_req, o_erase_req, i_erase_ack, i_erase_fault;
    logic o_timeout;
    logic [7:0] o_error_reg, o_sector_count_reg;
    logic [27:0] o_erase_lba;
    scd_class_type o_class;
    scd_op_type o_op;
    scd_params_type o_params;
    int fails = 0, n_tests = 0, acks = 0;
    logic [7:0] wc [11] = '{8'hc5, 8'hcd, 8'h3c, 8'h30, 8'h31, 8'h38,
        8'hca, 8'h32, 8'h33, 8'he8, 8'h50};
    logic [7:0] rc [17] = '{8'h20, 8'h21, 8'hc4, 8'hc8, 8'he5, 8'h98,
        8'he6, 8'h99, 8'he2, 8'h96, 8'he0, 8'h94, 8'h10, 8'h1f, 8'h70,
        8'h7a, 8'h00};
    scd_op_type ro [17] = '{SCD_OPK_RDSEC, SCD_OPK_RDSEC, SCD_OPK_RDMULT,
        SCD_OPK_RDDMA, SCD_OPK_CHKPWR, SCD_OPK_CHKPWR, SCD_OPK_SLEEP,
        SCD_OPK_SLEEP, SCD_OPK_STBY, SCD_OPK_STBY, SCD_OPK_STBYI,
        SCD_OPK_STBYI, SCD_OPK_RECAL, SCD_OPK_RECAL, SCD_OPK_SEEK,
        SCD_OPK_SEEK, SCD_OPK_NOP};

    scd_decoder scd_decoder_i (.*, .o_sc_load());
    scd_media_model scd_media_model_i (.i_clk, .i_rst,
        .i_erase_req(o_erase_req), .i_delay(dly), .i_fault_en(fault_en),
        .o_erase_ack(i_erase_ack), .o_erase_fault(i_erase_fault));

    always #2 i_clk = ~i_clk;
    always @(posedge i_clk) if (i_erase_ack) acks++;

    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // writes one command, then waits for busy to clear
    task automatic cmd(logic [7:0] c, scd_taskfile_type t);
        int n;
        n = 0;
        @(posedge i_clk);
        i_cmd_wr <= 1'b1;
        i_cmd_code <= c;
        i_taskfile <= t;
        @(posedge i_clk);
        i_cmd_wr <= 1'b0;
        #1;
        while (o_busy_flag !== 1'b0 && n < 2000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("idle", n < 2000, 1'b1);
    endtask : cmd

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        #100000;
        fails++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (wc[k]) begin
            cmd(wc[k], '0);
            chk("wclass", o_class, k < 3 ? 2'd3 : 2'd2);
            chk("wdrq", o_data_request_flag, 1'b1);
            chk("tmo", o_timeout, 1'b0);
        end
        @(posedge i_clk) i_buf_ready <= 1'b0;
        fork
            cmd(8'h30, '0);
            begin
                repeat (20) @(posedge i_clk);
                chk("early", o_data_request_flag, 1'b0);
                i_buf_ready <= 1'b1;
            end
        join
        $display("test writes done");
        foreach (rc[k]) begin
            cmd(rc[k], '0);
            chk("op", o_op, ro[k]);
            chk("rclass", o_class, SCD_CLS_ONE);
        end
        cmd(8'hb9, {8'h05, 40'h0});
        chk("key", o_op, SCD_OPK_KEY_STRUCT);
        cmd(8'hb9, {8'h80, 40'h0});
        chk("key", o_op, SCD_OPK_KEY_READ);
        cmd(8'hb9, {8'h81, 40'h0});
        chk("key", o_class, SCD_CLS_TWO);
        $display("test decode done");
        @(posedge i_clk) i_asleep <= 1'b1;
        cmd(8'h98, '0);
        chk("count", o_sector_count_reg, 8'h00);
        @(posedge i_clk) i_asleep <= 1'b0;
        cmd(8'he5, '0);
        chk("count", o_sector_count_reg, 8'hff);
        $display("test power done");
        @(posedge i_clk) i_self_test_code <= 8'h02;
        cmd(8'h90, 48'h0f);
        chk("diag", o_error_reg, 8'h02);
        chk("ef", o_error_flag, 1'b1);
        chk("head", o_params.head_valid, 1'b0);
        @(posedge i_clk) i_self_test_code <= 8'h05;
        cmd(8'h90, 48'h10);
        chk("unsel", o_error_reg, 8'h02);
        @(posedge i_clk) i_direct_disk_mode <= 1'b1;
        i_diag_pass_line <= 1'b0;
        i_self_test_code <= 8'h01;
        repeat (3) @(posedge i_clk);
        cmd(8'h90, 48'h10);
        chk("slave", o_error_reg, 8'h81);
        $display("test diag done");
        @(posedge i_clk) i_direct_disk_mode <= 1'b0;
        fault_en <= 1'b1;
        dly <= 4'h6;
        cmd(8'hc0, 48'h0003_6745_23e1);
        chk("lba", o_params.lba, 28'h1234567);
        chk("sc_v", o_params.sc_valid, 1'b1);
        chk("acks", acks, 3);
        chk("elba", o_erase_lba, 28'h123456a);
        chk("wf", o_write_fault_flag, 1'b1);
        chk("drq", o_data_request_flag, 1'b0);
        @(posedge i_clk) fault_en <= 1'b0;
        dly <= 4'h1;
        cmd(8'hc0, 48'h0000_0000_00e0);
        chk("acks", acks, 259);
        chk("wf", o_write_fault_flag, 1'b0);
        $display("test erase done");
        cmd(8'hff, '0);
        chk("err", o_error_flag, 1'b1);
        chk("abort", o_abort, 1'b1);
        $display("test abort done");
        end_sim();
    end
endmodule : tb_scd_decoder
